// >>> src/scc_channel.sv
// control and status for one serdes channel
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ps
`include "scc_params.svh"
module scc_channel #(
  parameter int CH_INDEX = 0,
  parameter int BOND_WIDTH = 1,
  parameter int FIFO_AW = 3,
  parameter int DET_CYC = 4,
  parameter int SCAN_CYC = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // mode selection
  input wire logic gigabit_ethernet_mode,
  input wire logic basic_8b10b_mode,
  input wire logic pipe_mode,
  input wire logic bonded_in,
  // transmit control
  input wire logic tx_logic_reset,
  input wire logic force_idle,
  input wire logic [1:0] power_down,
  input wire logic eios_sent,
  input wire logic [7:0] user_data,
  input wire logic user_valid,
  // receiver detect
  input wire logic det_req,
  input wire logic rx_present,
  // receive control
  input wire logic rx_analog_reset,
  input wire logic rx_digital_reset,
  input wire logic force_data_lock,
  input wire logic force_ref_lock,
  input wire logic cdr_data_ok,
  input wire logic rx_above_threshold,
  input wire logic recov_clk_in,
  input wire logic [3:0] slip_raw,
  input wire logic manual_align_mode,
  // fifo traffic and bonded shared control
  input wire logic fifo_wr,
  input wire logic fifo_rd,
  input wire logic bond_full_in,
  input wire logic bond_empty_in,
  // pll reconfiguration
  input wire logic pll_update_req,
  // transmit outputs
  output logic [7:0] tx_word,
  output logic tx_is_comma,
  output logic tx_elec_idle,
  // detect answer
  output logic phy_done,
  output logic [2:0] phy_status,
  // receive status
  output logic rx_fifo_fault,
  output logic [3:0] slip_count_out,
  output logic cdr_lock_data,
  output logic lock_to_reference,
  output logic signal_present,
  output logic recov_clk_out,
  // bonding status
  output logic bond_legal,
  output logic fifo_full,
  output logic fifo_empty,
  // pll reconfiguration answer
  output logic scan_finished,
  output logic pll_areset_req
);
  localparam int EI_HOLD = `SCC_EI_HOLD_CYC;
  localparam int EI_ENTER = `SCC_EI_ENTER_CYC;

  typedef struct packed {
    scc_pkg::scc_tx_t tx_st;
    logic [1:0] comma_cnt;
    logic [7:0] word;
    logic comma;
    logic idle;
    logic [7:0] idle_cnt;
    logic [7:0] enter_cnt;
    logic enter_pend;
    logic fault;
    logic [3:0] slip;
    logic lock_data;
    logic lock_ref;
    logic sig;
    logic scan_busy;
    logic [7:0] scan_cnt;
    logic scan_done;
    logic areset;
  } scc_ch_t;

  scc_ch_t s_q;
  scc_ch_t s_d;
  logic own_full;
  logic own_empty;
  logic use_full;
  logic use_empty;
  logic is_bonded;
  logic det_req_ok;

  // ----------------------------------------
  // sub blocks
  // ----------------------------------------
  // detect only taken in the low power state, a stray request is dropped
  assign det_req_ok = det_req && (power_down == `SCC_LOW_POWER_ONE) && s_q.idle;

  scc_detect #(
    .DET_CYC(DET_CYC)
  ) u_det (
    .clk(clk),
    .rstn(rstn),
    .det_req(det_req_ok),
    .rx_present(rx_present),
    .phy_done(phy_done),
    .phy_status(phy_status)
  );

  scc_pcfifo #(
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .wr_en(fifo_wr),
    .rd_en(fifo_rd),
    .full(own_full),
    .empty(own_empty)
  );

  // ----------------------------------------
  // bonding
  // ----------------------------------------
  // legal bonding groups only
  assign bond_legal = (BOND_WIDTH == 1) || (BOND_WIDTH == 4) || ((BOND_WIDTH == 2) && (CH_INDEX < 2));
  assign is_bonded = bonded_in && bond_legal && (BOND_WIDTH > 1);
  // bonded channels follow shared pointer status for the fault flag only
  // non-bonded channels use their own pointers
  assign use_full = is_bonded ? bond_full_in : own_full;
  assign use_empty = is_bonded ? bond_empty_in : own_empty;
  assign fifo_full = own_full;
  assign fifo_empty = own_empty;

  // recovered clock passes only in gigabit ethernet
  assign recov_clk_out = gigabit_ethernet_mode & recov_clk_in;

  assign tx_word = s_q.word;
  assign tx_is_comma = s_q.comma;
  assign tx_elec_idle = s_q.idle;
  assign rx_fifo_fault = s_q.fault;
  assign slip_count_out = s_q.slip;
  assign cdr_lock_data = s_q.lock_data;
  assign lock_to_reference = s_q.lock_ref;
  assign signal_present = s_q.sig;
  assign scan_finished = s_q.scan_done;
  assign pll_areset_req = s_q.areset;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.comma = 1'b0;
    s_d.scan_done = 1'b0;
    s_d.areset = 1'b0;
    // start-up commas ahead of user data, in gigabit ethernet mode only
    case (s_q.tx_st)
      scc_pkg::SCC_TX_RESET:
      begin
        s_d.word = 8'h00;
        if (!tx_logic_reset)
        begin
          s_d.tx_st = gigabit_ethernet_mode ? scc_pkg::SCC_TX_COMMA : scc_pkg::SCC_TX_USER;
          s_d.comma_cnt = 2'h0;
        end
      end
      scc_pkg::SCC_TX_COMMA:
      begin
        s_d.word = `SCC_K28_5;
        s_d.comma = 1'b1;
        s_d.comma_cnt = s_q.comma_cnt + 2'h1;
        if (s_q.comma_cnt == `SCC_COMMA_COUNT - 2'h1)
        begin
          s_d.tx_st = scc_pkg::SCC_TX_USER;
        end
      end
      scc_pkg::SCC_TX_USER:
      begin
        // odd data spacing is left to the fabric
        if (user_valid)
        begin
          s_d.word = user_data;
        end
      end
      default:
      begin
        s_d.tx_st = scc_pkg::SCC_TX_RESET;
      end
    endcase
    if (tx_logic_reset)
    begin
      s_d.tx_st = scc_pkg::SCC_TX_RESET;
    end
    // idle entry after the ordered set, bounded by enter count
    if (eios_sent && !s_q.idle)
    begin
      s_d.enter_pend = 1'b1;
      s_d.enter_cnt = 8'h00;
    end
    if (s_q.enter_pend)
    begin
      s_d.enter_cnt = s_q.enter_cnt + 8'h01;
      if (s_q.enter_cnt >= 8'(EI_ENTER - 1))
      begin
        s_d.idle = 1'b1;
        s_d.enter_pend = 1'b0;
        s_d.idle_cnt = 8'h00;
      end
    end
    if (force_idle && !s_q.idle)
    begin
      s_d.idle = 1'b1;
      s_d.enter_pend = 1'b0;
      s_d.idle_cnt = 8'h00;
    end
    // minimum idle dwell before leaving
    if (s_q.idle)
    begin
      if (s_q.idle_cnt != 8'hff)
      begin
        s_d.idle_cnt = s_q.idle_cnt + 8'h01;
      end
      if (!force_idle && !eios_sent && (s_q.idle_cnt >= 8'(EI_HOLD - 1)))
      begin
        s_d.idle = 1'b0;
      end
    end
    // fifo fault level
    s_d.fault = use_full | use_empty;
    // slip count clamped to nine, zero outside manual mode
    s_d.slip = !manual_align_mode ? 4'h0 : ((slip_raw > `SCC_SLIP_MAX) ? `SCC_SLIP_MAX : slip_raw);
    // lock mode select, analog reset forces reference, otherwise data lock wins over reference
    if (rx_analog_reset)
    begin
      s_d.lock_ref = 1'b1;
      s_d.lock_data = 1'b0;
    end
    else if (force_data_lock)
    begin
      s_d.lock_ref = 1'b0;
      s_d.lock_data = 1'b1;
    end
    else if ({force_data_lock, force_ref_lock} == `SCC_LOCK_REF)
    begin
      s_d.lock_ref = 1'b1;
      s_d.lock_data = 1'b0;
    end
    else
    begin
      s_d.lock_ref = !cdr_data_ok;
      s_d.lock_data = cdr_data_ok;
    end
    // lock flag mirrors data lock
    s_d.lock_data = s_d.lock_data & !s_d.lock_ref;
    // signal present only in modes that offer it
    s_d.sig = (basic_8b10b_mode | pipe_mode) & rx_above_threshold & !rx_digital_reset;
    // pll scan under held resets, then done and reset pulse
    if (pll_update_req && !s_q.scan_busy && tx_logic_reset && rx_analog_reset && rx_digital_reset)
    begin
      s_d.scan_busy = 1'b1;
      s_d.scan_cnt = 8'h00;
    end
    if (s_q.scan_busy)
    begin
      s_d.scan_cnt = s_q.scan_cnt + 8'h01;
      if (s_q.scan_cnt == 8'(SCAN_CYC - 1))
      begin
        s_d.scan_busy = 1'b0;
        s_d.scan_done = 1'b1;
      end
    end
    // pll reset pulse follows scan done by one cycle
    if (s_q.scan_done)
    begin
      s_d.areset = 1'b1;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // reset leaves the transmitter idle and the cdr on reference
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
      s_q.idle <= 1'b1;
      s_q.lock_ref <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule

// >>> src/scc_params.svh
// constants for the serdes channel control block
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH
`define SCC_CLK_PERIOD_PS 25000
`define SCC_EI_ENTER_NS 8
`define SCC_EI_HOLD_NS 20
`define SCC_EI_ENTER_CYC (((`SCC_EI_ENTER_NS * 1000) / `SCC_CLK_PERIOD_PS) < 1 ? 1 : ((`SCC_EI_ENTER_NS * 1000) / `SCC_CLK_PERIOD_PS))
`define SCC_EI_HOLD_CYC (((`SCC_EI_HOLD_NS * 1000) + `SCC_CLK_PERIOD_PS - 1) / `SCC_CLK_PERIOD_PS)
`define SCC_DET_MIN_CYC 10
`define SCC_STATUS_FOUND 3'h3
`define SCC_STATUS_NONE 3'h0
`define SCC_COMMA_COUNT 2'h3
`define SCC_K28_5 8'hbc
`define SCC_SLIP_MAX 4'h9
`define SCC_LOW_POWER_ONE 2'h2
`define SCC_LOCK_AUTO 2'h0
`define SCC_LOCK_REF 2'h1
`endif

// >>> src/scc_pkg.sv
// types for the serdes channel control block
package scc_pkg;
  typedef enum logic [1:0] {
    SCC_DET_IDLE = 2'b00,
    SCC_DET_RUN  = 2'b01,
    SCC_DET_DONE = 2'b10
  } scc_det_t;
  typedef enum logic [1:0] {
    SCC_TX_RESET = 2'b00,
    SCC_TX_COMMA = 2'b01,
    SCC_TX_USER  = 2'b10
  } scc_tx_t;
endpackage

// >>> src/scc_pcfifo.sv
// phase compensation fifo pointer and status block
`timescale 1ns/1ps
`include "scc_params.svh"
module scc_pcfifo #(
  parameter int AW = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pointer control
  input wire logic wr_en,
  input wire logic rd_en,
  // status
  output logic full,
  output logic empty
);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } scc_pf_t;
  scc_pf_t s_q;
  scc_pf_t s_d;
  logic do_wr;
  logic do_rd;
  assign full = (s_q.wp[AW] != s_q.rp[AW]) && (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]);
  assign empty = (s_q.wp == s_q.rp);
  assign do_wr = wr_en && !full;
  assign do_rd = rd_en && !empty;
  always_comb
  begin
    s_d = s_q;
    if (do_wr)
    begin
      s_d.wp = s_q.wp + {{AW{1'b0}}, 1'b1};
    end
    if (do_rd)
    begin
      s_d.rp = s_q.rp + {{AW{1'b0}}, 1'b1};
    end
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule

// >>> src/scc_detect.sv
// receiver detect handshake sequencer
`timescale 1ns/1ps
`include "scc_params.svh"
module scc_detect #(
  parameter int DET_CYC = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // request and line result
  input wire logic det_req,
  input wire logic rx_present,
  // answer
  output logic phy_done,
  output logic [2:0] phy_status
);
  typedef struct packed {
    scc_pkg::scc_det_t st;
    logic [7:0] cnt;
    logic found;
    logic done;
    logic [2:0] status;
  } scc_dt_t;
  scc_dt_t s_q;
  scc_dt_t s_d;
  assign phy_done = s_q.done;
  assign phy_status = s_q.status;
  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      scc_pkg::SCC_DET_IDLE:
      begin
        if (det_req)
        begin
          s_d.st = scc_pkg::SCC_DET_RUN;
          s_d.cnt = '0;
        end
      end
      scc_pkg::SCC_DET_RUN:
      begin
        s_d.cnt = s_q.cnt + 8'h01;
        if (s_q.cnt == 8'(DET_CYC - 1))
        begin
          s_d.st = scc_pkg::SCC_DET_DONE;
          s_d.found = rx_present;
        end
      end
      scc_pkg::SCC_DET_DONE:
      begin
        // one-cycle done with the detection result
        s_d.done = 1'b1;
        s_d.status = s_q.found ? `SCC_STATUS_FOUND : `SCC_STATUS_NONE;
        s_d.st = scc_pkg::SCC_DET_IDLE;
      end
      default:
      begin
        s_d.st = scc_pkg::SCC_DET_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule

// >>> sim/scc_channel_chk.sv
// assertion checker for the serdes channel control block
`timescale 1ns/1ps
module scc_channel_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // watched controls
  input wire logic gigabit_ethernet_mode,
  input wire logic tx_logic_reset,
  input wire logic force_idle,
  input wire logic eios_sent,
  input wire logic force_data_lock,
  input wire logic rx_analog_reset,
  input wire logic basic_8b10b_mode,
  input wire logic pipe_mode,
  input wire logic bonded_in,
  // watched status
  input wire logic [7:0] tx_word,
  input wire logic tx_is_comma,
  input wire logic tx_elec_idle,
  input wire logic phy_done,
  input wire logic [2:0] phy_status,
  input wire logic rx_fifo_fault,
  input wire logic fifo_full,
  input wire logic fifo_empty,
  input wire logic signal_present,
  input wire logic [3:0] slip_count_out,
  input wire logic cdr_lock_data,
  input wire logic lock_to_reference,
  input wire logic recov_clk_out,
  input wire logic scan_finished,
  input wire logic pll_areset_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_commas;
    (tx_is_comma && tx_word == 8'hbc) [*3];
  endsequence
  property p_comma;
    gigabit_ethernet_mode && $fell(tx_logic_reset) |-> ##2 s_commas ##1 !tx_is_comma;
  endproperty
  a_comma: assert property (p_comma) else $error("comma burst wrong");
  property p_done;
    phy_done |=> !phy_done;
  endproperty
  a_done: assert property (p_done) else $error("done not a pulse");
  property p_eios;
    eios_sent |-> ##[1:2] tx_elec_idle;
  endproperty
  a_eios: assert property (p_eios) else $error("idle entry late");
  property p_force;
    force_idle |=> tx_elec_idle;
  endproperty
  a_force: assert property (p_force) else $error("forced idle lost");
  property p_slip;
    slip_count_out <= 4'h9;
  endproperty
  a_slip: assert property (p_slip) else $error("slip count above nine");
  property p_lock;
    cdr_lock_data != lock_to_reference;
  endproperty
  a_lock: assert property (p_lock) else $error("lock flags agree");
  property p_data;
    force_data_lock && !rx_analog_reset |=> cdr_lock_data;
  endproperty
  a_data: assert property (p_data) else $error("data lock ignored");
  property p_recov;
    !gigabit_ethernet_mode |-> !recov_clk_out;
  endproperty
  a_recov: assert property (p_recov) else $error("recovered clock leaks");
  property p_pll;
    scan_finished |=> pll_areset_req && !scan_finished;
  endproperty
  a_pll: assert property (p_pll) else $error("pll reset missing");
  property p_status;
    phy_done |-> (phy_status == 3'h3) || (phy_status == 3'h0);
  endproperty
  a_status: assert property (p_status) else $error("detect status code wrong");
  property p_fault;
    !bonded_in && (fifo_full || fifo_empty) |=> rx_fifo_fault;
  endproperty
  a_fault: assert property (p_fault) else $error("fifo fault missing");
  property p_sig;
    !basic_8b10b_mode && !pipe_mode |=> !signal_present;
  endproperty
  a_sig: assert property (p_sig) else $error("signal present outside its modes");
endmodule
bind scc_channel scc_channel_chk i_scc_channel_chk (.clk, .rstn, .gigabit_ethernet_mode,
  .tx_logic_reset, .force_idle, .eios_sent, .force_data_lock, .rx_analog_reset, .basic_8b10b_mode,
  .pipe_mode, .bonded_in, .tx_word, .tx_is_comma, .tx_elec_idle, .phy_done, .phy_status,
  .rx_fifo_fault, .fifo_full, .fifo_empty, .signal_present, .slip_count_out, .cdr_lock_data,
  .lock_to_reference, .recov_clk_out, .scan_finished, .pll_areset_req);

// >>> sim/scc_far_model.sv
// far-side line partner model
`timescale 1ns/1ps
module scc_far_model (
  // clock and command
  input wire logic clk,
  input wire logic link_up,
  // line status
  output logic rx_present = 1'h0,
  output logic cdr_data_ok = 1'h0,
  output logic rx_above_threshold = 1'h0,
  output logic recov_clk_in = 1'h0
);
  // clock stands still while the link is down
  always @(posedge clk)
  begin
    rx_present <= link_up;
    cdr_data_ok <= link_up;
    rx_above_threshold <= link_up;
    recov_clk_in <= link_up & ~recov_clk_in;
  end
endmodule

// >>> sim/scc_channel_tb_top.sv
// self-checking bench for the serdes channel control block
`timescale 1ns/1ps
module scc_channel_tb_top;
  logic clk = 1'h0, rstn = 1'h0, gigabit_ethernet_mode = 1'h1, basic_8b10b_mode = 1'h0;
  logic pipe_mode = 1'h0, bonded_in = 1'h0, tx_logic_reset = 1'h1, force_idle = 1'h0, eios_sent = 1'h0;
  logic user_valid = 1'h0, det_req = 1'h0, rx_analog_reset = 1'h0, rx_digital_reset = 1'h0;
  logic force_data_lock = 1'h0, force_ref_lock = 1'h0, manual_align_mode = 1'h0, fifo_wr = 1'h0;
  logic fifo_rd = 1'h0, bond_full_in = 1'h0, bond_empty_in = 1'h0, pll_update_req = 1'h0, link_up = 1'h0;
  logic [1:0] power_down = 2'h0;
  logic [7:0] user_data = 8'h0;
  logic [3:0] slip_raw = 4'h0;
  logic rx_present, cdr_data_ok, rx_above_threshold, recov_clk_in, tx_is_comma, tx_elec_idle, phy_done;
  logic rx_fifo_fault, cdr_lock_data, lock_to_reference, signal_present, recov_clk_out, bond_legal;
  logic fifo_full, fifo_empty, scan_finished, pll_areset_req, e;
  logic [7:0] tx_word, w;
  logic [2:0] phy_status;
  logic [3:0] slip_count_out;
  logic [2:0] exp_q[$];
  int bad_count = 0, num_checks = 0, n;
  scc_channel #(.BOND_WIDTH(2)) i_scc_channel (.clk, .rstn, .gigabit_ethernet_mode, .basic_8b10b_mode,
    .pipe_mode, .bonded_in, .tx_logic_reset, .force_idle, .power_down, .eios_sent, .user_data,
    .user_valid, .det_req, .rx_present, .rx_analog_reset, .rx_digital_reset, .force_data_lock,
    .force_ref_lock, .cdr_data_ok, .rx_above_threshold, .recov_clk_in, .slip_raw, .manual_align_mode,
    .fifo_wr, .fifo_rd, .bond_full_in, .bond_empty_in, .pll_update_req, .tx_word, .tx_is_comma,
    .tx_elec_idle, .phy_done, .phy_status, .rx_fifo_fault, .slip_count_out, .cdr_lock_data,
    .lock_to_reference, .signal_present, .recov_clk_out, .bond_legal, .fifo_full, .fifo_empty,
    .scan_finished, .pll_areset_req);
  scc_far_model i_scc_far_model (.clk, .link_up, .rx_present, .cdr_data_ok, .rx_above_threshold,
    .recov_clk_in);
  always #12.5 clk = ~clk;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] want, input string what);
    num_checks++;
    if (seen !== want)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // refused requests push nothing, so a stray done meets 3'h7
  task automatic detect(input logic p, input logic [1:0] pd);
    force_idle <= 1'h1;
    power_down <= pd;
    link_up <= p;
    cyc(10);
    det_req <= 1'h1;
    if (pd == 2'h2)
      exp_q.push_back(p ? 3'h3 : 3'h0);
    cyc(1);
    det_req <= 1'h0;
    cyc(12);
    chk(8'(exp_q.size()), 8'h0, "pending detect");
    force_idle <= 1'h0;
    // let the low reach the design before a next call raises it again
    cyc(1);
  endtask
  always @(negedge clk)
    if (phy_done === 1'h1)
    begin
      chk(phy_status, exp_q.size() ? exp_q[0] : 3'h7, "detect status");
      if (exp_q.size())
        void'(exp_q.pop_front());
    end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'ha3c7ee0d));
    cyc(10);
    chk(tx_elec_idle, 1'h1, "reset idle");
    chk(lock_to_reference, 1'h1, "reset ref lock");
    rstn <= 1'h1;
    cyc(2);
    tx_logic_reset <= 1'h0;
    n = 0;
    repeat (10)
    begin
      @(negedge clk);
      n += (tx_is_comma === 1'h1 && tx_word === 8'hbc);
    end
    chk(8'(n), 8'h3, "comma count");
    @(posedge clk);
    w = 8'($urandom) & 8'h7f;
    user_data <= w;
    user_valid <= 1'h1;
    cyc(1);
    user_data <= 8'hbc;
    @(negedge clk);
    chk(tx_word, w, "user word");
    chk(tx_is_comma, 1'h0, "user not comma");
    @(posedge clk);
    user_valid <= 1'h0;
    @(negedge clk);
    chk(tx_word, 8'hbc, "sync comma word");
    @(posedge clk);
    $display("end comma");
    detect(1'h1, 2'h2);
    detect(1'h0, 2'h2);
    detect(1'h1, 2'h0);
    eios_sent <= 1'h1;
    @(negedge clk);
    chk(tx_elec_idle, 1'h0, "idle left");
    @(posedge clk);
    eios_sent <= 1'h0;
    cyc(1);
    @(negedge clk);
    chk(tx_elec_idle, 1'h1, "eios idle");
    cyc(3);
    $display("end detect");
    for (int i = 0; i < 8; i++)
    begin
      {link_up, force_data_lock, force_ref_lock} <= 3'(i);
      {gigabit_ethernet_mode, basic_8b10b_mode, pipe_mode} <= 3'($urandom);
      manual_align_mode <= i[0];
      slip_raw <= 4'($urandom);
      cyc(3);
      @(negedge clk);
      e = force_data_lock | (!force_ref_lock & link_up);
      chk(cdr_lock_data, e, "data lock");
      chk(lock_to_reference, !e, "ref lock");
      chk(signal_present, (basic_8b10b_mode | pipe_mode) & link_up, "signal");
      chk(recov_clk_out, gigabit_ethernet_mode & recov_clk_in, "recov clk");
      chk(slip_count_out, manual_align_mode ? (slip_raw > 4'h9 ? 4'h9 : slip_raw) : 4'h0, "slip");
    end
    $display("end status");
    chk(rx_fifo_fault, 1'h1, "fault empty");
    @(posedge clk);
    fifo_wr <= 1'h1;
    n = 0;
    while (fifo_full !== 1'h1 && n < 64)
    begin
      @(negedge clk);
      n++;
    end
    // eight entries, plus the sample taken before the first write lands
    chk(8'(n), 8'h9, "fill depth");
    @(posedge clk);
    fifo_wr <= 1'h0;
    fifo_rd <= 1'h1;
    cyc(1);
    fifo_rd <= 1'h0;
    cyc(2);
    @(negedge clk);
    chk(rx_fifo_fault, 1'h0, "fault mid");
    chk(bond_legal, 1'h1, "bond legal");
    @(posedge clk);
    bonded_in <= 1'h1;
    fifo_rd <= 1'h1;
    n = 0;
    while (fifo_empty !== 1'h1 && n < 64)
    begin
      @(negedge clk);
      n++;
    end
    chk(8'(n), 8'h8, "drain depth");
    @(posedge clk);
    fifo_rd <= 1'h0;
    cyc(2);
    @(negedge clk);
    chk(rx_fifo_fault, 1'h0, "shared fault");
    @(posedge clk);
    bond_empty_in <= 1'h1;
    cyc(2);
    @(negedge clk);
    chk(rx_fifo_fault, 1'h1, "shared empty");
    $display("end fifo");
    @(posedge clk);
    {tx_logic_reset, rx_analog_reset, rx_digital_reset} <= 3'h7;
    cyc(2);
    pll_update_req <= 1'h1;
    cyc(1);
    pll_update_req <= 1'h0;
    n = 0;
    while (scan_finished !== 1'h1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    chk(scan_finished, 1'h1, "scan done");
    @(negedge clk);
    chk(pll_areset_req, 1'h1, "pll reset");
    chk(lock_to_reference, 1'h1, "analog reset ref");
    @(posedge clk);
    gigabit_ethernet_mode <= 1'h0;
    {tx_logic_reset, rx_analog_reset, rx_digital_reset} <= 3'h0;
    n = 0;
    repeat (8)
    begin
      @(negedge clk);
      n += (tx_is_comma === 1'h1);
    end
    chk(8'(n), 8'h0, "plain start commas");
    $display("end pll");
    complete_run();
  end
  initial
  begin
    #50us;
    bad_count++;
    complete_run();
  end
endmodule
